// ### core/rtp_oam_header_framer.sv
// Purpose: rtp header builder, oam word builder, receive oam classifier
// Assumes: tx request holds fields stable until txDone; rx header word given per packet
// Notes: ticks from other clocks pass two flops here before use
`timescale 1ns/1ns
`include "rtp_oam_regs.svh"
module rtp_oam_header_framer (
    input wire logic clk,
    input wire logic rstn,
    input wire logic tdmTickPin,
    input wire logic refTickPin,
    input wire logic absMode,
    input wire logic tsFine,
    input wire logic delayMeasEn,
    input wire logic [6:0] payloadType,
    input wire logic [31:0] ssrc,
    input wire logic [15:0] channelType,
    input wire logic txReq,
    input wire logic [3:0] txPayload,
    input wire logic [2:0] txOamKind,
    input wire logic [15:0] cwSeq,
    input wire logic [15:0] bundleId,
    input wire logic [15:0] oamBundleId,
    input wire logic txReply,
    input wire logic [15:0] rxOamSeq,
    input wire logic locFail,
    input wire logic remFail,
    input wire logic [1:0] defectMod,
    input wire logic [7:0] oamLength,
    input wire logic [7:0] oamCode,
    input wire logic lookupWe,
    input wire logic [2:0] lookupIdx,
    input wire logic [15:0] lookupId,
    input wire logic rxValid,
    input wire logic [15:0] rxBundleId,
    input wire logic [31:0] rxFirstWord,
    output logic txValid,
    output logic [31:0] txWord,
    output logic txDone,
    output logic [15:0] txBundle,
    output logic txTsValid,
    output logic [31:0] txOamTs,
    output logic rxOut,
    output logic rxToOam,
    output logic rxToTdm,
    output logic rxIsVccv
);
    logic [1:0] tdmSync_r;
    logic [1:0] refSync_r;
    logic tdmPrev_r;
    logic refPrev_r;
    logic tdmTick;
    logic refTick;
    ts_if ts ();
    rtp_oam_pkg::tx_state_t state_r;
    logic [15:0] oamSeq_r;
    logic [15:0] lookup_r [`OAM_LOOKUP_DEPTH];

    // two-flop synchronisers; edges detected on the second stage only
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            tdmSync_r <= 2'h0;
            refSync_r <= 2'h0;
            tdmPrev_r <= 1'b0;
            refPrev_r <= 1'b0;
        end else begin
            tdmSync_r <= {tdmSync_r[0], tdmTickPin};
            refSync_r <= {refSync_r[0], refTickPin};
            tdmPrev_r <= tdmSync_r[1];
            refPrev_r <= refSync_r[1];
        end
    end
    assign tdmTick = tdmSync_r[1] & ~tdmPrev_r;
    assign refTick = refSync_r[1] & ~refPrev_r;

    ts_counter tsCnt (
        .clk(clk),
        .rstn(rstn),
        .absMode(absMode),
        .tdmFrameTick(tdmTick),
        .refTick(refTick),
        .tsFine(tsFine),
        .ts(ts)
    );

    function automatic logic inLookup(input logic [15:0] id);
        logic hit;
        hit = 1'b0;
        for (int i = 0; i < `OAM_LOOKUP_DEPTH; i++) begin
            if (lookup_r[i] == id) begin
                hit = 1'b1;
            end
        end
        return hit;
    endfunction

    // oam bundle identifier lookup, written from configuration port
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            for (int i = 0; i < `OAM_LOOKUP_DEPTH; i++) begin
                lookup_r[i] <= 16'hffff;
            end
        end else if (lookupWe) begin
            lookup_r[lookupIdx] <= lookupId;
        end
    end

    logic isOam;
    logic isVccv;
    logic isUdp;
    assign isOam = txPayload == rtp_oam_pkg::PL_OAM;
    assign isVccv = isOam && txOamKind == rtp_oam_pkg::OAM_VCCV;
    assign isUdp = isOam && txOamKind == rtp_oam_pkg::OAM_UDP;

    logic [31:0] rtpW0;
    logic [31:0] oamW0;
    logic [31:0] oamW1;
    logic [31:0] w0;
    logic [31:0] w1;
    logic [31:0] w2;
    logic [15:0] seqOut;
    logic [7:0] msgType;
    logic [1:0] lastIdx;
    // version 2, p/x/cc/m zero, shared payload type accepted as given
    assign rtpW0 = {`RTP_VERSION, 1'b0, 1'b0, 4'h0, 1'b0, payloadType, cwSeq};
    assign seqOut = txReply ? rxOamSeq : oamSeq_r;
    assign msgType = txReply ? `MSG_REPLY : `MSG_QUERY;
    // vccv: nibble 0001, fmtid and res zero, channel type configured
    // udp: nibble 0000, l r m copied from the bundle
    always_comb begin
        if (isVccv) begin
            oamW0 = {`VCCV_NIBBLE, 4'h0, 8'h00, channelType};
            oamW1 = {msgType, oamCode, seqOut};
        end else begin
            // length field is six bits; upper bits of oamLength are not carried
            oamW0 = {`UDP_OAM_NIBBLE, locFail, remFail, defectMod, 2'h0, oamLength[5:0], seqOut};
            oamW1 = {msgType, oamCode, 16'h0000};
        end
    end
    always_comb begin
        if (isOam) begin
            w0 = oamW0;
            w1 = oamW1;
            w2 = isUdp ? {oamBundleId, bundleId} : 32'h0;
            lastIdx = isUdp ? 2'h2 : 2'h1;
        end else begin
            w0 = rtpW0;
            w1 = ts.rtpTs;
            w2 = ssrc;
            lastIdx = 2'h2;
        end
    end

    // tx word sequencer, one word per cycle
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state_r <= rtp_oam_pkg::TX_IDLE;
            txValid <= 1'b0;
            txWord <= 32'h0;
            txDone <= 1'b0;
        end else begin
            txDone <= 1'b0;
            case (state_r)
                rtp_oam_pkg::TX_IDLE: begin
                    txValid <= 1'b0;
                    if (txReq) begin
                        state_r <= rtp_oam_pkg::TX_W0;
                    end
                end
                rtp_oam_pkg::TX_W0: begin
                    txValid <= 1'b1;
                    txWord <= w0;
                    state_r <= rtp_oam_pkg::TX_W1;
                end
                rtp_oam_pkg::TX_W1: begin
                    txWord <= w1;
                    if (lastIdx == 2'h1) begin
                        txDone <= 1'b1;
                        state_r <= rtp_oam_pkg::TX_IDLE;
                    end else begin
                        state_r <= rtp_oam_pkg::TX_W2;
                    end
                end
                rtp_oam_pkg::TX_W2: begin
                    txWord <= w2;
                    txDone <= 1'b1;
                    state_r <= rtp_oam_pkg::TX_IDLE;
                end
                default: begin
                    state_r <= rtp_oam_pkg::TX_IDLE;
                    txValid <= 1'b0;
                end
            endcase
        end
    end

    // psn layers: same bundle for data and vccv, oam id swapped in for udp
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            txBundle <= 16'h0;
            txTsValid <= 1'b0;
            txOamTs <= 32'h0;
        end else if (txReq && state_r == rtp_oam_pkg::TX_IDLE) begin
            txBundle <= isUdp ? oamBundleId : bundleId;
            txTsValid <= isOam && delayMeasEn;
            txOamTs <= (isOam && delayMeasEn) ? ts.oamTs : 32'h0;
        end
    end

    // query sequence only moves when a query request is accepted, before its words go out
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            oamSeq_r <= 16'h0;
        end else if (txReq && state_r == rtp_oam_pkg::TX_IDLE && isOam && !txReply) begin
            oamSeq_r <= oamSeq_r + 16'h1;
        end
    end

    // receive classification; checked before any control word decode
    logic rxVccv;
    logic rxUdp;
    assign rxVccv = rxFirstWord[31:28] == `VCCV_NIBBLE;
    assign rxUdp = inLookup(rxBundleId);
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rxOut <= 1'b0;
            rxToOam <= 1'b0;
            rxToTdm <= 1'b0;
            rxIsVccv <= 1'b0;
        end else begin
            rxOut <= rxValid;
            rxToOam <= rxValid && (rxVccv || rxUdp);
            rxToTdm <= rxValid && !(rxVccv || rxUdp);
            rxIsVccv <= rxValid && rxVccv && !rxUdp;
        end
    end
endmodule

// ### core/rtp_oam_regs.svh
// Purpose: constants for the rtp header / oam framer
// Assumes: 32-bit words, msb first on the wire
// Notes: no software registers; configuration arrives on ports
// How it works
// - rtp version field always two
// - padding, extension, marker, csrc count zero
// - same payload type allowed everywhere
// - rtp sequence copies control word sequence
// - absolute mode timestamps follow tdm clock
// - absolute mode adds one per 125us
// - common clock mode uses network reference
// - aal1, hdlc, raw and oam payloads supported
// - vccv oam reuses data bundle identifier
// - leading nibble 0001 marks vccv oam
// - vccv oam diverted before control word use
// - vccv oam psn layers match data
// - vccv format id and reserved zero
// - vccv channel type is configured constant
// - udp oam bundle id must be in lookup
// - udp oam swaps bundle id only
// - message type zero query, eight reply
// - oam sequence advances on query, echoed on reply
// - oam l, r, m copied from bundle
// - oam timestamps 100us or 1us, when enabled
`ifndef RTP_OAM_REGS_SVH
`define RTP_OAM_REGS_SVH
`define RTP_VERSION 2'h2
`define VCCV_NIBBLE 4'h1
`define UDP_OAM_NIBBLE 4'h0
`define MSG_QUERY 8'h00
`define MSG_REPLY 8'h08
`define TDM_FRAME_NS 125000
`define TS_COARSE_NS 100000
`define TS_FINE_NS 1000
`define CLK_NS 10
`define OAM_LOOKUP_DEPTH 8
`define CHANNEL_TYPE_DEFAULT 16'h0000
`define HDR_WORDS 3
`endif

// ### core/rtp_oam_pkg.sv
// Purpose: types shared by the framer modules
// Assumes: nothing
// Notes: constants live in rtp_oam_regs.svh
package rtp_oam_pkg;
    typedef enum logic [3:0] {
        PL_AAL1 = 4'b0001,
        PL_HDLC = 4'b0010,
        PL_RAW = 4'b0100,
        PL_OAM = 4'b1000
    } payload_t;
    typedef enum logic [2:0] {
        OAM_NONE = 3'b001,
        OAM_VCCV = 3'b010,
        OAM_UDP = 3'b100
    } oam_kind_t;
    typedef enum logic [3:0] {
        TX_IDLE = 4'b0001,
        TX_W0 = 4'b0010,
        TX_W1 = 4'b0100,
        TX_W2 = 4'b1000
    } tx_state_t;
endpackage

// ### core/ts_if.sv
// Purpose: timestamp tick bundle between counter and framer
// Assumes: single clock
// Notes: none
`timescale 1ns/1ns
interface ts_if;
    logic [31:0] rtpTs;
    logic [31:0] oamTs;
    modport src (output rtpTs, output oamTs);
    modport dst (input rtpTs, input oamTs);
endinterface

// ### core/ts_counter.sv
// Purpose: rtp and oam timestamp counters
// Assumes: tdm and reference ticks already synchronised, one-cycle pulses
// Notes: oam resolution via prescaler of the core clock
`timescale 1ns/1ns
`include "rtp_oam_regs.svh"
module ts_counter (
    input wire logic clk,
    input wire logic rstn,
    input wire logic absMode,
    input wire logic tdmFrameTick,
    input wire logic refTick,
    input wire logic tsFine,
    ts_if.src ts
);
    localparam int COARSE_CYC = `TS_COARSE_NS / `CLK_NS;
    localparam int FINE_CYC = `TS_FINE_NS / `CLK_NS;
    logic [31:0] rtpTs_r;
    logic [31:0] oamTs_r;
    logic [13:0] pre_r;
    logic preDone;
    assign preDone = tsFine ? (pre_r >= 14'(FINE_CYC - 1)) : (pre_r >= 14'(COARSE_CYC - 1));
    // one step per 125us frame of the tdm clock, or per reference tick
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rtpTs_r <= 32'h0;
        end else if (absMode ? tdmFrameTick : refTick) begin
            rtpTs_r <= rtpTs_r + 32'h1;
        end
    end
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pre_r <= 14'h0;
            oamTs_r <= 32'h0;
        end else if (preDone) begin
            pre_r <= 14'h0;
            oamTs_r <= oamTs_r + 32'h1;
        end else begin
            pre_r <= pre_r + 14'h1;
        end
    end
    assign ts.rtpTs = rtpTs_r;
    assign ts.oamTs = oamTs_r;
endmodule

// ### dv/rtp_oam_header_framer_assertions.sv
// Purpose: port-level checks of header words and receive steering
// Assumes: request fields held until txDone
// Notes: bound to the framer at the foot of this file
`timescale 1ns/1ns
module rtp_oam_header_framer_assertions (
    input wire logic clk,
    input wire logic rstn,
    input wire logic [6:0] payloadType,
    input wire logic [15:0] channelType,
    input wire logic [3:0] txPayload,
    input wire logic [2:0] txOamKind,
    input wire logic [15:0] cwSeq,
    input wire logic [15:0] bundleId,
    input wire logic [15:0] oamBundleId,
    input wire logic txReply,
    input wire logic locFail,
    input wire logic remFail,
    input wire logic [1:0] defectMod,
    input wire logic [7:0] oamCode,
    input wire logic rxValid,
    input wire logic [31:0] rxFirstWord,
    input wire logic txValid,
    input wire logic [31:0] txWord,
    input wire logic txDone,
    input wire logic [15:0] txBundle,
    input wire logic rxToOam,
    input wire logic rxToTdm
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    wire logic isRtp = txPayload != rtp_oam_pkg::PL_OAM;
    wire logic isVccv = !isRtp && txOamKind == rtp_oam_pkg::OAM_VCCV;
    wire logic isUdp = !isRtp && txOamKind == rtp_oam_pkg::OAM_UDP;
    property p_rtp_version;
        $rose(txValid) && isRtp |-> txWord[31:30] == 2'h2;
    endproperty
    a_rtp_version: assert property (p_rtp_version) else $error("rtp version wrong");
    property p_rtp_zero;
        $rose(txValid) && isRtp |-> txWord[29:23] == 7'h00;
    endproperty
    a_rtp_zero: assert property (p_rtp_zero) else $error("rtp flag bits set");
    property p_rtp_pt;
        $rose(txValid) && isRtp |-> txWord[22:16] == payloadType ##2 txDone;
    endproperty
    a_rtp_pt: assert property (p_rtp_pt) else $error("payload type or length wrong");
    property p_rtp_seq;
        $rose(txValid) && isRtp |-> txWord[15:0] == cwSeq;
    endproperty
    a_rtp_seq: assert property (p_rtp_seq) else $error("rtp sequence differs");
    property p_vccv_head;
        $rose(txValid) && isVccv |-> txWord[31:16] == 16'h1000;
    endproperty
    a_vccv_head: assert property (p_vccv_head) else $error("vccv head bits wrong");
    property p_vccv_chan;
        $rose(txValid) && isVccv |-> txWord[15:0] == channelType ##1 txDone;
    endproperty
    a_vccv_chan: assert property (p_vccv_chan) else $error("vccv channel type wrong");
    property p_vccv_bundle;
        $rose(txValid) && isVccv |-> txBundle == bundleId;
    endproperty
    a_vccv_bundle: assert property (p_vccv_bundle) else $error("vccv bundle differs");
    property p_udp_flags;
        $rose(txValid) && isUdp |-> txWord[31:24] == {4'h0, locFail, remFail, defectMod};
    endproperty
    a_udp_flags: assert property (p_udp_flags) else $error("udp oam flag byte wrong");
    property p_udp_type;
        $rose(txValid) && isUdp |-> ##1 txWord[31:16] == {(txReply ? 8'h08 : 8'h00), oamCode};
    endproperty
    a_udp_type: assert property (p_udp_type) else $error("oam message type wrong");
    property p_udp_ids;
        $rose(txValid) && isUdp |-> ##2 txDone && txWord == {oamBundleId, bundleId};
    endproperty
    a_udp_ids: assert property (p_udp_ids) else $error("udp oam bundle word wrong");
    property p_rx_divert;
        rxValid && rxFirstWord[31:28] == 4'h1 |=> rxToOam && !rxToTdm;
    endproperty
    a_rx_divert: assert property (p_rx_divert) else $error("vccv packet not diverted");
endmodule
bind rtp_oam_header_framer rtp_oam_header_framer_assertions u_chk (.clk, .rstn, .payloadType, .channelType,
    .txPayload, .txOamKind, .cwSeq, .bundleId, .oamBundleId, .txReply, .locFail, .remFail, .defectMod,
    .oamCode, .rxValid, .rxFirstWord, .txValid, .txWord, .txDone, .txBundle, .rxToOam, .rxToTdm);

// ### dv/remote_gateway_model.sv
// Purpose: far gateway that loops each sent packet head back
// Assumes: one packet in flight
// Notes: slow adds six cycles of turnaround
`timescale 1ns/1ns
module remote_gateway_model (
    input wire logic clk,
    input wire logic rstn,
    input wire logic slow,
    input wire logic txValid,
    input wire logic [31:0] txWord,
    input wire logic txDone,
    input wire logic [15:0] txBundle,
    output logic rxValid = 1'b0,
    output logic [15:0] rxBundleId = 16'h0000,
    output logic [31:0] rxFirstWord = 32'h0000_0000
);
    logic busy = 1'b0;
    logic [31:0] head;
    logic [15:0] bund;
    int lag = -1;
    always @(posedge clk) begin
        rxValid <= 1'b0;
        if (!rstn) begin
            busy = 1'b0;
            lag = -1;
        end else begin
            if (txValid && !busy) head = txWord;
            busy = txValid && !txDone;
            if (txDone) begin
                bund = txBundle;
                lag = slow ? 6 : 0;
            end else if (lag > 0) lag--;
        end
        if (lag == 0) begin
            rxValid <= 1'b1;
            rxFirstWord <= head;
            rxBundleId <= bund;
            lag = -1;
        end else begin
            // released lines must not hold the last head
            rxFirstWord <= ~rxFirstWord;
            rxBundleId <= ~rxBundleId;
        end
    end
endmodule

// ### dv/test_rtp_oam_header_framer.sv
// Purpose: directed scenarios for the rtp / oam framer
// Assumes: far end echoes every packet head
// Notes: no randomness
`timescale 1ns/1ns
module test_rtp_oam_header_framer;
    logic clk = 1'b0, rstn = 1'b0, slow = 1'b0, tdmTickPin = 1'b0, refTickPin = 1'b0, absMode = 1'b1;
    logic tsFine = 1'b0, delayMeasEn = 1'b0, txReq = 1'b0, txReply = 1'b0, locFail = 1'b0, remFail = 1'b0;
    logic lookupWe = 1'b0;
    logic [6:0] payloadType = 7'h60;
    logic [31:0] ssrc = 32'h5a3c_96e1;
    logic [15:0] channelType = 16'h00a5, cwSeq = 16'h0000, bundleId = 16'h0123, oamBundleId = 16'h0456;
    logic [15:0] rxOamSeq = 16'h7e5d, lookupId = 16'h0000, rxBundleId, txBundle;
    logic [3:0] txPayload = 4'h1;
    logic [2:0] txOamKind = 3'h1, lookupIdx = 3'h0, rx;
    logic [1:0] defectMod = 2'h0;
    logic [7:0] oamLength = 8'h20, oamCode = 8'h01;
    logic txValid, txDone, txTsValid, rxOut, rxToOam, rxToTdm, rxIsVccv, rxValid;
    logic [31:0] txWord, txOamTs, rxFirstWord;
    logic [31:0] w[3];
    int num_errors = 0, num_checks = 0, nw;
    rtp_oam_header_framer i_dut (.clk, .rstn, .tdmTickPin, .refTickPin, .absMode, .tsFine, .delayMeasEn,
        .payloadType, .ssrc, .channelType, .txReq, .txPayload, .txOamKind, .cwSeq, .bundleId, .oamBundleId,
        .txReply, .rxOamSeq, .locFail, .remFail, .defectMod, .oamLength, .oamCode, .lookupWe, .lookupIdx,
        .lookupId, .rxValid, .rxBundleId, .rxFirstWord, .txValid, .txWord, .txDone, .txBundle, .txTsValid,
        .txOamTs, .rxOut, .rxToOam, .rxToTdm, .rxIsVccv);
    remote_gateway_model i_far (.clk, .rstn, .slow, .txValid, .txWord, .txDone, .txBundle, .rxValid,
        .rxBundleId, .rxFirstWord);
    initial begin
        forever #5 clk = ~clk;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic send(input logic [3:0] pl, input logic [2:0] ok);
        @(posedge clk);
        txPayload <= pl;
        txOamKind <= ok;
        txReq <= 1'b1;
        @(posedge clk);
        txReq <= 1'b0;
        nw = 0;
        for (int n = 0; n < 12 && txDone !== 1'b1; n++) begin
            @(negedge clk);
            if (txValid === 1'b1 && nw < 3) begin
                w[nw] = txWord;
                nw++;
            end
        end
    endtask
    task automatic rxwait;
        for (int n = 0; n < 16 && rxOut !== 1'b1; n++) @(negedge clk);
        rx = {rxToOam, rxToTdm, rxIsVccv};
        chk(rxOut, 1);
    endtask
    task automatic ticks(input int n, input logic tdm);
        repeat (n) begin
            @(posedge clk);
            if (tdm) tdmTickPin <= 1'b1;
            else refTickPin <= 1'b1;
            repeat (4) @(posedge clk);
            tdmTickPin <= 1'b0;
            refTickPin <= 1'b0;
            repeat (4) @(posedge clk);
        end
    endtask
    task automatic t_rtp;
        logic [3:0] pl[3] = '{rtp_oam_pkg::PL_AAL1, rtp_oam_pkg::PL_HDLC, rtp_oam_pkg::PL_RAW};
        for (int i = 0; i < 3; i++) begin
            @(posedge clk);
            cwSeq <= 16'hfffe + 16'(i);
            slow <= i[0];
            send(pl[i], rtp_oam_pkg::OAM_NONE);
            chk(w[0], {2'h2, 7'h00, payloadType, 16'hfffe + 16'(i)});
            chk(w[2], ssrc);
            rxwait;
            chk(rx, 3'b010);
        end
    endtask
    task automatic t_ts;
        logic [31:0] t0;
        for (int m = 1; m >= 0; m--) begin
            @(posedge clk);
            absMode <= m[0];
            send(rtp_oam_pkg::PL_RAW, rtp_oam_pkg::OAM_NONE);
            t0 = w[1];
            ticks(3, 1'b1);
            ticks(2, 1'b0);
            send(rtp_oam_pkg::PL_RAW, rtp_oam_pkg::OAM_NONE);
            chk(w[1], t0 + (m == 1 ? 32'd3 : 32'd2));
        end
    endtask
    task automatic t_vccv;
        send(rtp_oam_pkg::PL_OAM, rtp_oam_pkg::OAM_VCCV);
        chk(nw, 2);
        chk(w[0], {16'h1000, channelType});
        chk(w[1][31:16], {8'h00, oamCode});
        chk(w[1][15:0], 16'h0001);
        chk(txBundle, bundleId);
        rxwait;
        chk(rx, 3'b101);
    endtask
    task automatic t_udp;
        @(posedge clk);
        tsFine <= 1'b1;
        lookupWe <= 1'b1;
        lookupIdx <= 3'h7;
        lookupId <= oamBundleId;
        @(posedge clk);
        lookupWe <= 1'b0;
        for (int i = 0; i < 3; i++) begin
            @(posedge clk);
            txReply <= (i == 2);
            delayMeasEn <= i[0];
            locFail <= i[0];
            remFail <= !i[0];
            defectMod <= 2'(i);
            send(rtp_oam_pkg::PL_OAM, rtp_oam_pkg::OAM_UDP);
            chk(w[0][31:24], {4'h0, i[0], !i[0], 2'(i)});
            chk(w[0][15:0], i == 2 ? rxOamSeq : 16'(2 + i));
            chk(w[1][31:24], i == 2 ? 8'h08 : 8'h00);
            chk(w[2], {oamBundleId, bundleId});
            chk(txTsValid, i[0]);
            chk(txOamTs == 32'h0, !i[0]);
            rxwait;
            chk(rx, 3'b100);
        end
    endtask
    task automatic final_report;
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        t_rtp;
        t_ts;
        t_vccv;
        t_udp;
        final_report;
    end
    initial begin
        // whole run is well under two thousand cycles
        #50000;
        num_errors++;
        final_report;
    end
endmodule
